// >>> reset_cause_params.svh
// constants of the reset cause and init block
`ifndef RESET_CAUSE_PARAMS_SVH
`define RESET_CAUSE_PARAMS_SVH
// ****************************************
// control codes
// ****************************************
`define UV_CODE_ENABLE 8'h5A
`define UV_CODE_DISABLE 8'hA5
`define WE_CODE_ENABLE 5'h0A
`define WE_CODE_DISABLE 5'h15
`define WE_MSB 7
`define WE_LSB 3
// ****************************************
// reset values
// ****************************************
`define WATCHDOG_CONTROL_REG_INIT 8'h53
`define UVC_INIT 8'h5A
`define PORT_INIT 8'hFF
// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 4
`define SRESET_DELAY_NS 64
`define SRESET_CYCLES ((`SRESET_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// >>> reset_cause_pkg.sv
// types of the reset cause and init block
package reset_cause_pkg;
    typedef enum logic [1:0] {MODE_FAST, MODE_SLOW, MODE_IDLE, MODE_SLEEP} mode_t;
    typedef struct packed {
        logic wdtExpiry;
        logic powerdown;
    } status_t;
    typedef struct packed {
        logic uvEvent;
        logic uvSwReset;
        logic wdSwReset;
    } swflags_t;
    typedef struct packed {
        status_t status;
        swflags_t sw;
    } cause_t;
    typedef struct packed {
        logic sysReset;
        logic pcClear;
        logic spTop;
        logic intDisable;
        logic timersOff;
        logic counterClear;
    } init_t;
    typedef struct packed {
        logic [2:0] lvSync;
        logic lvStable;
        logic [7:0] uvDelay;
        logic [7:0] wdDelay;
        cause_t cause;
        init_t init;
        logic [7:0] uvCtl;
        logic [7:0] wdtCtl;
        logic [2:0][7:0] portData;
        logic [2:0][7:0] portDir;
    } state_t;
endpackage : reset_cause_pkg

// >>> reset_cause_and_init_logic.sv
// reset cause flags and reset initialisation of the core
`include "reset_cause_params.svh"

// Operation
// - an undefined undervoltage control code sets its software-reset flag
// - that flag is cleared only by a software clear strobe of one or by power-on reset
// - watchdog expiry in fast or slow mode resets and sets expiry flag
// - such a reset keeps the power-down flag unchanged
// - watchdog expiry when idle or asleep clears only PC and stack pointer
// - such an expiry leaves expiry and power-down flags both at one
// - a low-voltage reset in fast or slow mode keeps both flags
// - expiry and power-down flags clear to zero on power-on reset
// - power-on reset zeroes program counter and disables all interrupts
// - power-on reset clears watchdog and time bases, watchdog then counts
// - power-on reset switches every timer module off
// - power-on reset makes every port pin an input
// - power-on reset points stack pointer at top of stack
// - control and port registers load defaults except on low-power watchdog reset; a low-voltage reset keeps the undervoltage code
// - undervoltage code enables, disables, or resets after fixed delay
// - undefined watchdog enable field resets after fixed delay
// - that reset sets watchdog software-reset flag, cleared only by software or by power-on reset
// - a real low-supply reset sets the undervoltage event flag
module reset_cause_and_init_logic #(
    parameter int SRESET_CYCLES = `SRESET_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire reset_cause_pkg::mode_t cpuMode,
    input wire logic wdtTimeout,
    input wire logic lowVoltagePin,
    input wire logic haltExec,
    input wire logic clrWdtExec,
    input wire logic uvCtlWrite,
    input wire logic [7:0] uvCtlWdata,
    input wire logic wdtCtlWrite,
    input wire logic [7:0] wdtCtlWdata,
    input wire logic [2:0] portDataWrite,
    input wire logic [2:0] portDirWrite,
    input wire logic [7:0] portWdata,
    input wire reset_cause_pkg::swflags_t flagClear,
    output reset_cause_pkg::cause_t cause,
    output reset_cause_pkg::init_t init,
    output logic [7:0] uvCtl,
    output logic [7:0] wdtCtl,
    output logic [2:0][7:0] portData,
    output logic [2:0][7:0] portDir
);
    import reset_cause_pkg::*;

    // ****************************************
    // parameter check
    // ****************************************
    generate
        if (SRESET_CYCLES < 1 || SRESET_CYCLES > 255)
        begin : g_bad_delay
            $error("SRESET_CYCLES must lie in 1..255");
        end
    endgenerate

    localparam logic [7:0] DELAY_LAST = 8'(SRESET_CYCLES - 1);

    state_t s;
    state_t next_s;
    logic running;
    logic lvrOn;
    logic lvrHit;
    logic uvBad;
    logic wdBad;
    logic uvFire;
    logic wdFire;
    logic wdtRun;
    logic wdtIdle;
    logic fullReset;
    logic [2:0][7:0] portDataWr;
    logic [2:0][7:0] portDirWr;

    // ****************************************
    // per port software write
    // ****************************************
    generate
        for (genvar i = 0; i < 3; i++)
        begin : g_port
            assign portDataWr[i] = portDataWrite[i] ? portWdata : s.portData[i];
            assign portDirWr[i] = portDirWrite[i] ? portWdata : s.portDir[i];
        end
    endgenerate

    // ****************************************
    // reset sources
    // ****************************************
    assign running = (cpuMode == MODE_FAST) || (cpuMode == MODE_SLOW);
    // detector is off in the low-power modes
    assign lvrOn = running && (s.uvCtl == `UV_CODE_ENABLE);
    assign lvrHit = lvrOn && (s.lvSync[2] == s.lvSync[1]) && s.lvSync[2] && !s.lvStable;
    assign uvBad = (s.uvCtl != `UV_CODE_ENABLE)
        && (s.uvCtl != `UV_CODE_DISABLE);
    assign wdBad = (s.wdtCtl[`WE_MSB:`WE_LSB] != `WE_CODE_ENABLE)
        && (s.wdtCtl[`WE_MSB:`WE_LSB] != `WE_CODE_DISABLE);
    assign uvFire = uvBad && (s.uvDelay == DELAY_LAST);
    assign wdFire = wdBad && (s.wdDelay == DELAY_LAST);
    assign wdtRun = wdtTimeout && running;
    assign wdtIdle = wdtTimeout && !running;
    assign fullReset = lvrHit || wdtRun || uvFire || wdFire;

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        next_s = s;
        // first stage feeds the second only
        next_s.lvSync = {s.lvSync[1:0], lowVoltagePin};
        // an off detector forgets the level, so a supply still low on wake-up resets
        if (!lvrOn)
        begin
            next_s.lvStable = 1'b0;
        end
        else if (s.lvSync[2] == s.lvSync[1])
        begin
            next_s.lvStable = s.lvSync[2];
        end
        // delay counters restart once the code is legal again
        next_s.uvDelay = (uvBad && !uvFire) ? s.uvDelay + 8'h01 : 8'h00;
        next_s.wdDelay = (wdBad && !wdFire) ? s.wdDelay + 8'h01 : 8'h00;

        // init pulses last one cycle
        next_s.init = '0;
        if (fullReset)
        begin
            next_s.init = '1;
        end
        else if (wdtIdle)
        begin
            next_s.init.pcClear = 1'b1;
            next_s.init.spTop = 1'b1;
        end

        // registers: reset load beats software write
        if (wdtRun || uvFire || wdFire || lvrHit)
        begin
            next_s.wdtCtl = `WATCHDOG_CONTROL_REG_INIT;
            for (int i = 0; i < 3; i++)
            begin
                next_s.portData[i] = `PORT_INIT;
                next_s.portDir[i] = `PORT_INIT;
            end
            // a true low-supply reset keeps the undervoltage code
            if (!lvrHit || wdtRun || uvFire || wdFire)
            begin
                next_s.uvCtl = `UVC_INIT;
            end
        end
        else if (!wdtIdle)
        begin
            // writes in the idle expiry cycle are dropped, registers hold
            if (uvCtlWrite)
            begin
                next_s.uvCtl = uvCtlWdata;
            end
            if (wdtCtlWrite)
            begin
                next_s.wdtCtl = wdtCtlWdata;
            end
            next_s.portData = portDataWr;
            next_s.portDir = portDirWr;
        end

        // expiry flag: set wins over clear
        if (wdtTimeout)
        begin
            next_s.cause.status.wdtExpiry = 1'b1;
        end
        else if (clrWdtExec)
        begin
            next_s.cause.status.wdtExpiry = 1'b0;
        end
        // power-down flag: only halt or idle expiry set it
        if (wdtIdle || haltExec)
        begin
            next_s.cause.status.powerdown = 1'b1;
        end
        else if (clrWdtExec)
        begin
            next_s.cause.status.powerdown = 1'b0;
        end
        // running expiry and low-voltage reset leave powerdown alone

        // software flags: set wins over clear
        if (lvrHit)
        begin
            next_s.cause.sw.uvEvent = 1'b1;
        end
        else if (flagClear.uvEvent)
        begin
            next_s.cause.sw.uvEvent = 1'b0;
        end
        if (uvFire)
        begin
            next_s.cause.sw.uvSwReset = 1'b1;
        end
        else if (flagClear.uvSwReset)
        begin
            next_s.cause.sw.uvSwReset = 1'b0;
        end
        if (wdFire)
        begin
            next_s.cause.sw.wdSwReset = 1'b1;
        end
        else if (flagClear.wdSwReset)
        begin
            next_s.cause.sw.wdSwReset = 1'b0;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            s.lvSync <= 3'h0;
            s.lvStable <= 1'b0;
            s.uvDelay <= 8'h00;
            s.wdDelay <= 8'h00;
            s.cause <= '0;
            // init pulses stand through reset and the first cycle after
            s.init <= '1;
            s.uvCtl <= `UVC_INIT;
            s.wdtCtl <= `WATCHDOG_CONTROL_REG_INIT;
            s.portData <= {3{`PORT_INIT}};
            s.portDir <= {3{`PORT_INIT}};
        end
        else
        begin
            s <= next_s;
        end
    end

    assign cause = s.cause;
    assign init = s.init;
    assign uvCtl = s.uvCtl;
    assign wdtCtl = s.wdtCtl;
    assign portData = s.portData;
    assign portDir = s.portDir;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    sequence s_uvFire;
        uvBad && s.uvDelay == DELAY_LAST;
    endsequence

    sequence s_wdFire;
        wdBad && s.wdDelay == DELAY_LAST;
    endsequence

    property p_wdt_run;
        wdtRun |=> cause.status.wdtExpiry && init.sysReset
            && cause.status.powerdown == ($past(haltExec) || ($past(cause.status.powerdown) && !$past(clrWdtExec)))
            && wdtCtl == `WATCHDOG_CONTROL_REG_INIT;
    endproperty
    a_wdt_run: assert property (p_wdt_run) else $error("running expiry wrong");

    property p_wdt_idle;
        wdtIdle && !fullReset |=> cause.status.wdtExpiry && cause.status.powerdown
            && init.pcClear && init.spTop && !init.sysReset
            && uvCtl == $past(uvCtl) && portDir == $past(portDir);
    endproperty
    a_wdt_idle: assert property (p_wdt_idle) else $error("idle expiry wrong");

    property p_lvr_keep;
        lvrHit && !wdtTimeout && !haltExec && !clrWdtExec
            |=> cause.status == $past(cause.status) && init.sysReset;
    endproperty
    a_lvr_keep: assert property (p_lvr_keep) else $error("lvr changed flags");

    property p_uv_fire;
        s_uvFire |=> cause.sw.uvSwReset && uvCtl == `UVC_INIT && init.sysReset;
    endproperty
    a_uv_fire: assert property (p_uv_fire) else $error("uv code reset missing");

    property p_uv_hold;
        cause.sw.uvSwReset && !flagClear.uvSwReset |=> cause.sw.uvSwReset;
    endproperty
    a_uv_hold: assert property (p_uv_hold) else $error("uv sw flag lost");

    property p_wd_fire;
        wdBad && !wdtCtlWrite && !fullReset && !wdtIdle && s.wdDelay == 8'h00
            |-> ##[1:255] s_wdFire ##1 (cause.sw.wdSwReset && init.sysReset);
    endproperty
    a_wd_fire: assert property (p_wd_fire) else $error("wd code reset missing");

    property p_uv_event;
        lvrHit |=> cause.sw.uvEvent ##1 (cause.sw.uvEvent || $past(flagClear.uvEvent));
    endproperty
    a_uv_event: assert property (p_uv_event) else $error("uv event flag wrong");

    property p_por;
        disable iff (1'b0) $fell(rst) |-> (cause.status == '0 && init == '1
            && portDir == {3{`PORT_INIT}} && wdtCtl == `WATCHDOG_CONTROL_REG_INIT) ##1 (!init.counterClear || $past(fullReset));
    endproperty
    a_por: assert property (p_por) else $error("power-on state wrong");

endmodule : reset_cause_and_init_logic

// >>> tb.sv
// self-checking bench of the reset cause and init block
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import reset_cause_pkg::*;
    // short software-reset delay keeps the run brief
    localparam int SR = 2;
    typedef struct packed {
        mode_t m;
        logic halt;
        logic [1:0] st;
        logic [5:0] in;
        logic [7:0] pa;
        logic [7:0] wd;
    } row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    mode_t cpuMode = MODE_FAST;
    logic wdtTimeout = 1'b0;
    logic lowVoltagePin = 1'b0;
    logic haltExec = 1'b0;
    logic clrWdtExec = 1'b0;
    logic uvCtlWrite = 1'b0;
    logic [7:0] uvCtlWdata = 8'h00;
    logic wdtCtlWrite = 1'b0;
    logic [7:0] wdtCtlWdata = 8'h00;
    logic [2:0] portDataWrite = 3'h0;
    logic [2:0] portDirWrite = 3'h0;
    logic [7:0] portWdata = 8'h00;
    swflags_t flagClear = 3'h0;
    cause_t cause;
    init_t init;
    logic [7:0] uvCtl;
    logic [7:0] wdtCtl;
    logic [2:0][7:0] portData;
    logic [2:0][7:0] portDir;
    int errCount = 0;
    int nCompared = 0;
    int cycles = 0;
    row_t rows [4] = '{
        '{MODE_FAST, 1'b0, 2'b10, 6'h3F, 8'hFF, 8'h53},
        '{MODE_SLOW, 1'b1, 2'b11, 6'h3F, 8'hFF, 8'h53},
        '{MODE_IDLE, 1'b0, 2'b11, 6'h18, 8'h12, 8'hAB},
        '{MODE_SLEEP, 1'b1, 2'b11, 6'h18, 8'h12, 8'hAB}};

    always #2 clk = ~clk;

    reset_cause_and_init_logic #(.SRESET_CYCLES(SR)) i_reset_cause_and_init_logic (
        .clk(clk), .rst(rst), .cpuMode(cpuMode), .wdtTimeout(wdtTimeout),
        .lowVoltagePin(lowVoltagePin), .haltExec(haltExec), .clrWdtExec(clrWdtExec),
        .uvCtlWrite(uvCtlWrite), .uvCtlWdata(uvCtlWdata), .wdtCtlWrite(wdtCtlWrite),
        .wdtCtlWdata(wdtCtlWdata), .portDataWrite(portDataWrite), .portDirWrite(portDirWrite),
        .portWdata(portWdata), .flagClear(flagClear), .cause(cause), .init(init),
        .uvCtl(uvCtl), .wdtCtl(wdtCtl), .portData(portData), .portDir(portDir));

    // ****************************************
    // helpers
    // ****************************************
    task final_report;
        $display("compared %0d, mismatches %0d", nCompared, errCount);
        if (errCount == 0 && nCompared > 0)
        begin
            $display("No errors found");
        end
        else
        begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    task tick;
        @(posedge clk);
        #1;
    endtask : tick

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        nCompared++;
        if (seen !== exp)
        begin
            errCount++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task wr_ctl(input bit isUv, input logic [7:0] d);
        uvCtlWdata = d;
        wdtCtlWdata = d;
        uvCtlWrite = isUv;
        wdtCtlWrite = !isUv;
        tick;
        uvCtlWrite = 1'b0;
        wdtCtlWrite = 1'b0;
    endtask : wr_ctl

    // clear instruction, then a halt in the next cycle if asked
    task clr_then_halt(input logic halt);
        clrWdtExec = 1'b1;
        tick;
        clrWdtExec = 1'b0;
        haltExec = halt;
        tick;
        haltExec = 1'b0;
    endtask : clr_then_halt

    // undefined code: reset after the delay, flag kept until software clears it
    task bad_code(input bit isUv);
        int n;
        wr_ctl(isUv, isUv ? 8'h3C : 8'h00);
        for (n = 1; n <= 20; n++)
        begin
            tick;
            if ((isUv ? cause.sw.uvSwReset : cause.sw.wdSwReset) === 1'b1)
                break;
        end
        chk(n, SR);
        chk(init, 6'h3F);
        chk(isUv ? uvCtl : wdtCtl, isUv ? 8'h5A : 8'h53);
        repeat (5) tick;
        chk(isUv ? cause.sw.uvSwReset : cause.sw.wdSwReset, 1'b1);
        flagClear = isUv ? 3'b010 : 3'b001;
        tick;
        flagClear = 3'h0;
        tick;
        chk(cause.sw, 3'h0);
    endtask : bad_code

    // ****************************************
    // hang guard
    // ****************************************
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            errCount++;
            final_report;
        end
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial
    begin
        repeat (10) @(posedge clk);
        #1;
        chk(cause, 5'h00);
        chk(init, 6'h3F);
        chk({uvCtl, wdtCtl}, 16'h5A53);
        chk(portDir, 24'hFF_FFFF);
        rst = 1'b0;
        tick;
        chk(init, 6'h00);
        foreach (rows[i])
        begin
            cpuMode = rows[i].m;
            portWdata = 8'h12;
            portDataWrite = 3'b001;
            portDirWrite = 3'b010;
            wr_ctl(1'b0, 8'hAB);
            portDataWrite = 3'h0;
            portDirWrite = 3'h0;
            clr_then_halt(rows[i].halt);
            wdtTimeout = 1'b1;
            tick;
            wdtTimeout = 1'b0;
            chk(cause.status, rows[i].st);
            chk(init, rows[i].in);
            chk({portData[0], portDir[1]}, {2{rows[i].pa}});
            chk(wdtCtl, rows[i].wd);
            tick;
            chk(init, 6'h00);
        end
        cpuMode = MODE_FAST;
        bad_code(1'b1);
        bad_code(1'b0);
        // defined codes never start the delayed reset
        wr_ctl(1'b1, 8'hA5);
        tick;
        wr_ctl(1'b0, 8'h53);
        repeat (SR + 4) tick;
        chk({cause.sw, uvCtl}, {3'h0, 8'hA5});
        wr_ctl(1'b1, 8'h5A);
        // low supply is ignored while idle
        cpuMode = MODE_IDLE;
        lowVoltagePin = 1'b1;
        repeat (10) tick;
        chk(cause.sw.uvEvent, 1'b0);
        clr_then_halt(1'b1);
        cpuMode = MODE_FAST;
        for (int n = 0; n < 10 && cause.sw.uvEvent !== 1'b1; n++)
            tick;
        lowVoltagePin = 1'b0;
        chk(cause.sw.uvEvent, 1'b1);
        chk(cause.status, 2'b01);
        chk(init, 6'h3F);
        repeat (8) tick;
        flagClear = 3'b100;
        tick;
        flagClear = 3'h0;
        tick;
        chk(cause.sw, 3'h0);
        // second power-on reset in mid-run
        haltExec = 1'b1;
        tick;
        haltExec = 1'b0;
        portWdata = 8'h00;
        portDirWrite = 3'b111;
        tick;
        portDirWrite = 3'h0;
        rst = 1'b1;
        tick;
        chk(cause, 5'h00);
        chk(portDir, 24'hFF_FFFF);
        rst = 1'b0;
        tick;
        chk(init, 6'h00);
        tick;
        chk(cause, 5'h00);
        final_report;
    end
endmodule : tb
